// >>> hw/ctw_pkg.sv
`default_nettype none
package ctw_pkg;
   // Transceiver mode field; the upper bit marks an active receiver.
   localparam logic [1:0] MODE_OFF    = 2'h0;
   localparam logic [1:0] MODE_WAKE   = 2'h1;
   localparam logic [1:0] MODE_RXONLY = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h3;

   // Power mode of the surrounding chip, driven by its mode sequencer.
   typedef enum logic [2:0] {
      CHIP_NORMAL   = 3'h0,
      CHIP_STOP     = 3'h1,
      CHIP_SLEEP    = 3'h2,
      CHIP_RESTART  = 3'h3,
      CHIP_FAILSAFE = 3'h4
   } ctw_chip_mode_t;

   typedef enum logic [1:0] {
      WK_IDLE = 2'h0,
      WK_DOM1 = 2'h1,
      WK_REC  = 2'h3,
      WK_DOM2 = 2'h2
   } ctw_wake_state_t;

   // Register map, byte addresses.
   localparam logic [2:0] ADDR_CTRL   = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h4;

   // Control register fields.
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_WDOG_BIT  = 2;
   localparam logic [1:0] CTRL_MODE_RST = MODE_OFF;
   localparam logic       CTRL_WDOG_RST = 1'b0;

   // Status register fields.
   localparam int ST_MODE_LSB    = 0;
   localparam int ST_WAKE_BIT    = 2;
   localparam int ST_IRQ_BIT     = 3;
   localparam int ST_FAULT_BIT   = 4;
   localparam int ST_TO_BIT      = 5;
   localparam int ST_ARMED_BIT   = 6;
   localparam int ST_GNDTERM_BIT = 7;

   typedef struct packed {
      logic       wdog_on_bus_wake;
      logic [1:0] mode;
   } ctw_ctrl_t;

   // Timing.
   localparam int CLK_PERIOD_NS       = 100;
   localparam int TX_EN_TIME_US       = 200;
   localparam int WAKE_PHASE_MIN_NS   = 500;
   localparam int WAKE_PHASE_MAX_US   = 1000;
   localparam int TX_DOM_TIMEOUT_US   = 2000;
   localparam int BUS_SILENCE_US      = 1000;
   localparam int TX_EN_CYC     = TX_EN_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int WAKE_MIN_CYC  = (WAKE_PHASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_MAX_CYC  = WAKE_PHASE_MAX_US * 1000 / CLK_PERIOD_NS;
   localparam int TX_TO_CYC     = TX_DOM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int SILENCE_CYC   = BUS_SILENCE_US * 1000 / CLK_PERIOD_NS;
endpackage : ctw_pkg
`default_nettype wire

// >>> hw/ctw_transceiver.sv
// Overview of operation
// - Starts Off; Off allowed in every chip mode.
// - Off mode ignores bus wake activity.
// - Normal only by command in chip Normal.
// - Normal: driver follows transmit input level.
// - Early dominant suppressed until input returns high.
// - Normal: bus state shown on receive output.
// - Receive-only: driver off; chip Normal/Stop only.
// - Wake Capable by command; forced on Fail-Safe.
// - Bus wake drives receive low until mode change.
// - Wake pattern: dominant, recessive, dominant, bounded.
// - After wake mode still reads Wake Capable.
// - Mode toggle rearms wake detection.
// - Chip Stop/Sleep/Fail-Safe entry rearms detection.
// - Wake in Stop/Normal: interrupt and status.
// - Stop wake enables watchdog if configured.
// - Sleep wake: restart request, status, no interrupt.
// - Fail-Safe wake: restart; Restart wake: no restart; interrupt stays high.
// - Ground termination only after bus silence.
// - Dominant time-out forces bus recessive.
// - Time-out keeps mode, sets bus fault.
// - Driver resumes once time-out condition clears.
// - Mode upper bit set for Normal/Receive-only.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module ctw_transceiver
   import ctw_pkg::*;
#(
   parameter int CNT_W        = 16,
   parameter int WAKE_MAX_C   = WAKE_MAX_CYC,
   parameter int TX_TO_C      = TX_TO_CYC,
   parameter int SILENCE_C    = SILENCE_CYC
)(
   // Clock and reset.
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   // Avalon-MM register slave.
   input  wire logic [2:0]     avs_address,
   input  wire logic           avs_read,
   input  wire logic           avs_write,
   input  wire logic [31:0]    avs_writedata,
   input  wire logic [3:0]     avs_byteenable,
   output logic [31:0]         avs_readdata,
   output logic                avs_waitrequest,
   // Chip power mode from the mode sequencer.
   input  wire ctw_chip_mode_t chip_mode,
   // Protocol controller pins.
   input  wire logic           can_tx_input,
   output logic                can_rx_output,
   output logic                irq_out_n,
   // Analog front end.
   input  wire logic           bus_rx_dec,
   output logic                bus_drive_dom,
   output logic                bus_drv_en,
   output logic                bus_gnd_term,
   // Requests to the chip sequencer and watchdog, one-cycle pulses.
   output logic                chip_restart_req,
   output logic                wdog_enable_req
);
   localparam logic [CNT_W-1:0] EN_C   = CNT_W'(TX_EN_CYC);
   localparam logic [CNT_W-1:0] WMIN_C = CNT_W'(WAKE_MIN_CYC);
   localparam logic [CNT_W-1:0] WMAX_C = CNT_W'(WAKE_MAX_C);
   localparam logic [CNT_W-1:0] TO_C   = CNT_W'(TX_TO_C);
   localparam logic [CNT_W-1:0] SIL_C  = CNT_W'(SILENCE_C);

   // Pin synchronisers.
   logic [1:0] tx_sync_r;
   logic [1:0] rx_sync_r;
   logic       tx_hi;
   logic       bus_dom;
   assign tx_hi   = tx_sync_r[1];
   assign bus_dom = ~rx_sync_r[1];

   // State.
   ctw_ctrl_t       ctrl_r;
   logic [1:0]      mode_prev_r;
   ctw_chip_mode_t  chip_prev_r;
   logic            wake_stat_r;
   logic            wake_irq_r;
   logic            fault_r;
   logic            armed_r;
   logic            woke_r;
   logic            gate_r;
   logic            to_act_r;
   logic [CNT_W-1:0] en_cnt_r;
   logic [CNT_W-1:0] to_cnt_r;
   logic [CNT_W-1:0] sil_cnt_r;
   logic [CNT_W-1:0] ph_cnt_r;
   ctw_wake_state_t wk_st_r;
   ctw_wake_state_t wk_st_nxt;
   logic            waitreq_r;
   logic [31:0]     rdata_r;
   logic            rx_out_r;
   logic            irq_n_r;
   logic            drv_dom_r;
   logic            drv_en_r;
   logic            gnd_r;
   logic            restart_r;
   logic            wdog_r;

   // Bus decode. A request is answered at the second edge after it appears.
   logic        bus_go;
   logic        bus_commit;
   logic        wr_ctrl;
   logic        wr_status;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   assign bus_go     = (avs_read | avs_write) & waitreq_r;
   assign bus_commit = avs_write & ~waitreq_r & avs_byteenable[0];
   assign wr_ctrl    = bus_commit & (avs_address == ADDR_CTRL);
   assign wr_status  = bus_commit & (avs_address == ADDR_STATUS);
   assign status_word = {24'h0, gnd_r, armed_r, to_act_r, fault_r,
                         wake_irq_r, wake_stat_r, ctrl_r.mode};
   assign rd_mux = (avs_address == ADDR_CTRL)   ? {29'h0, ctrl_r} :
                   (avs_address == ADDR_STATUS) ? status_word : 32'h0;

   // Mode selection legality per chip power mode.
   logic [1:0] req_mode;
   logic       req_legal;
   logic       chip_chg;
   logic       fs_entry;
   logic       rearm_chip;
   assign req_mode  = avs_writedata[CTRL_MODE_LSB +: 2];
   assign req_legal = (req_mode == MODE_OFF) ||
                      (req_mode == MODE_NORMAL && chip_mode == CHIP_NORMAL) ||
                      (req_mode == MODE_RXONLY &&
                       (chip_mode == CHIP_NORMAL || chip_mode == CHIP_STOP)) ||
                      (req_mode == MODE_WAKE && chip_mode != CHIP_FAILSAFE);
   assign chip_chg   = chip_mode != chip_prev_r;
   assign fs_entry   = chip_chg && chip_mode == CHIP_FAILSAFE;
   assign rearm_chip = chip_chg && (chip_mode == CHIP_STOP || chip_mode == CHIP_SLEEP ||
                                    chip_mode == CHIP_FAILSAFE);

   logic [1:0] mode_nxt;
   assign mode_nxt = fs_entry ? MODE_WAKE :
                     (wr_ctrl && req_legal) ? req_mode : ctrl_r.mode;

   logic in_normal;
   logic in_wake;
   logic rx_active;
   assign in_normal = ctrl_r.mode == MODE_NORMAL;
   assign in_wake   = ctrl_r.mode == MODE_WAKE;
   assign rx_active = ctrl_r.mode[1];

   // Wake pattern detector; only runs while armed in Wake Capable mode.
   logic wk_run;
   logic ph_ok;
   logic ph_long;
   logic wake_hit;
   assign wk_run   = in_wake & armed_r;
   assign ph_ok    = ph_cnt_r >= WMIN_C;
   assign ph_long  = ph_cnt_r >= WMAX_C;

   always_comb
   begin
      wk_st_nxt = wk_st_r;
      wake_hit  = 1'b0;
      case (wk_st_r)
         WK_IDLE:
         begin
            if (bus_dom)
               wk_st_nxt = WK_DOM1;
         end
         WK_DOM1:
         begin
            if (ph_long)
               wk_st_nxt = WK_IDLE;
            else if (!bus_dom)
               wk_st_nxt = ph_ok ? WK_REC : WK_IDLE;
         end
         WK_REC:
         begin
            if (ph_long)
               wk_st_nxt = WK_IDLE;
            else if (bus_dom)
               wk_st_nxt = ph_ok ? WK_DOM2 : WK_DOM1;
         end
         WK_DOM2:
         begin
            if (ph_long)
               wk_st_nxt = WK_IDLE;
            else if (!bus_dom)
            begin
               wk_st_nxt = WK_IDLE;
               wake_hit  = ph_ok;
            end
         end
         default:
            wk_st_nxt = WK_IDLE;
      endcase
      if (!wk_run)
      begin
         wk_st_nxt = WK_IDLE;
         wake_hit  = 1'b0;
      end
   end

   logic wk_edge;
   assign wk_edge = wk_st_nxt != wk_st_r;

   // Wake consequences depend on the chip mode at the moment of detection.
   logic wake_irq_set;
   logic wake_restart;
   logic wake_wdog;
   assign wake_irq_set = wake_hit &&
                         (chip_mode == CHIP_NORMAL || chip_mode == CHIP_STOP);
   assign wake_restart = wake_hit &&
                         (chip_mode == CHIP_SLEEP || chip_mode == CHIP_FAILSAFE);
   assign wake_wdog    = wake_hit && chip_mode == CHIP_STOP && ctrl_r.wdog_on_bus_wake;

   // Normal-mode transmit path.
   logic norm_entry;
   logic wake_entry;
   logic tx_dom_raw;
   assign norm_entry = in_normal && mode_prev_r != MODE_NORMAL;
   assign wake_entry = in_wake && mode_prev_r != MODE_WAKE;
   assign tx_dom_raw = in_normal & ~tx_hi;

   always_ff @(posedge clk_sys)
   begin
      tx_sync_r <= {tx_sync_r[0], can_tx_input};
      rx_sync_r <= {rx_sync_r[0], bus_rx_dec};
   end

   // Register file and bus handshake.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ctrl_r.mode             <= CTRL_MODE_RST;
         ctrl_r.wdog_on_bus_wake <= CTRL_WDOG_RST;
         waitreq_r               <= 1'b1;
         rdata_r                 <= 32'h0;
      end
      else
      begin
         ctrl_r.mode <= mode_nxt;
         if (wr_ctrl)
            ctrl_r.wdog_on_bus_wake <= avs_writedata[CTRL_WDOG_BIT];
         waitreq_r <= ~bus_go;
         if (bus_go)
            rdata_r <= rd_mux;
      end
   end

   // Status flags: a hardware set wins over a write-one clear.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wake_stat_r <= 1'b0;
         wake_irq_r  <= 1'b0;
         fault_r     <= 1'b0;
      end
      else
      begin
         wake_stat_r <= wake_hit |
                        (wake_stat_r & ~(wr_status & avs_writedata[ST_WAKE_BIT]));
         wake_irq_r  <= wake_irq_set |
                        (wake_irq_r & ~(wr_status & avs_writedata[ST_IRQ_BIT]));
         fault_r     <= (to_act_r == 1'b0 && to_cnt_r == TO_C && tx_dom_raw) |
                        (fault_r & ~(wr_status & avs_writedata[ST_FAULT_BIT]));
      end
   end

   // Mode history, arming and wake state.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         mode_prev_r <= MODE_OFF;
         chip_prev_r <= CHIP_NORMAL;
         armed_r     <= 1'b1;
         woke_r      <= 1'b0;
         wk_st_r     <= WK_IDLE;
         ph_cnt_r    <= '0;
      end
      else
      begin
         mode_prev_r <= ctrl_r.mode;
         chip_prev_r <= chip_mode;
         if (!in_wake || rearm_chip)
         begin
            armed_r <= 1'b1;
            woke_r  <= 1'b0;
         end
         else if (wake_hit)
         begin
            armed_r <= 1'b0;
            woke_r  <= 1'b1;
         end
         wk_st_r <= wk_st_nxt;
         // The sample that opens a phase counts too, so a minimum-length phase passes.
         if (!wk_run)
            ph_cnt_r <= '0;
         else if (wk_edge)
            ph_cnt_r <= CNT_W'(1);
         else if (!ph_long)
            ph_cnt_r <= ph_cnt_r + 1'b1;
      end
   end

   // Enable time, dominant time-out and bus silence counters.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         gate_r    <= 1'b1;
         en_cnt_r  <= '0;
         to_act_r  <= 1'b0;
         to_cnt_r  <= '0;
         sil_cnt_r <= '0;
      end
      else
      begin
         if (!in_normal || norm_entry)
         begin
            gate_r   <= 1'b1;
            en_cnt_r <= EN_C;
         end
         else if (en_cnt_r != '0)
            en_cnt_r <= en_cnt_r - 1'b1;
         else if (tx_hi)
            gate_r <= 1'b0;
         if (!tx_dom_raw)
         begin
            to_cnt_r <= '0;
            to_act_r <= 1'b0;
         end
         else if (to_cnt_r != TO_C)
            to_cnt_r <= to_cnt_r + 1'b1;
         else
            to_act_r <= 1'b1;
         if (!in_wake || wake_entry)
            sil_cnt_r <= SIL_C;
         else if (bus_dom)
            sil_cnt_r <= SIL_C;
         else if (sil_cnt_r != '0)
            sil_cnt_r <= sil_cnt_r - 1'b1;
      end
   end

   // Registered pin and request outputs.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         rx_out_r  <= 1'b1;
         irq_n_r   <= 1'b1;
         drv_dom_r <= 1'b0;
         drv_en_r  <= 1'b0;
         gnd_r     <= 1'b0;
         restart_r <= 1'b0;
         wdog_r    <= 1'b0;
      end
      else
      begin
         rx_out_r  <= rx_active ? rx_sync_r[1] :
                      ~(in_wake & (woke_r | wake_hit));
         irq_n_r   <= ~(wake_irq_r | wake_irq_set);
         drv_en_r  <= in_normal & ~gate_r & ~to_act_r;
         drv_dom_r <= tx_dom_raw & ~gate_r & ~to_act_r;
         gnd_r     <= in_wake & ~woke_r & (sil_cnt_r == '0);
         restart_r <= wake_restart;
         wdog_r    <= wake_wdog;
      end
   end

   assign avs_readdata     = rdata_r;
   assign avs_waitrequest  = waitreq_r;
   assign can_rx_output    = rx_out_r;
   assign irq_out_n        = irq_n_r;
   assign bus_drive_dom    = drv_dom_r;
   assign bus_drv_en       = drv_en_r;
   assign bus_gnd_term     = gnd_r;
   assign chip_restart_req = restart_r;
   assign wdog_enable_req  = wdog_r;
endmodule : ctw_transceiver
`default_nettype wire

// >>> tb/ctw_transceiver_assertions.sv
`default_nettype none
module ctw_transceiver_chk
   import ctw_pkg::*;
#(
   parameter int TX_TO_C = TX_TO_CYC
)(
   // Clock and reset.
   input wire logic           clk_sys,
   input wire logic           rst_n,
   // Register bus.
   input wire logic           avs_read,
   input wire logic           avs_write,
   input wire logic           avs_waitrequest,
   // Chip mode and pins.
   input wire ctw_chip_mode_t chip_mode,
   input wire logic           can_tx_input,
   input wire logic           can_rx_output,
   input wire logic           irq_out_n,
   input wire logic           bus_drive_dom,
   input wire logic           bus_drv_en,
   input wire logic           chip_restart_req,
   input wire logic           wdog_enable_req
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] dom_cnt_r;
   always_ff @(posedge clk_sys)
   begin
      dom_cnt_r <= (!rst_n || !bus_drive_dom) ? 32'h0 : dom_cnt_r + 32'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
   property p_bus_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_bus_pulse: assert property (p_bus_pulse) else $error("waitrequest low too long");
   property p_drive_follows;
      bus_drive_dom |-> bus_drv_en && !$past(can_tx_input, 3);
   endproperty
   a_drive_follows: assert property (p_drive_follows) else $error("drive without tx");
   property p_tx_timeout;
      bus_drive_dom |-> dom_cnt_r < 32'(TX_TO_C + 3);
   endproperty
   a_tx_timeout: assert property (p_tx_timeout) else $error("dominant too long");
   property p_drv_chip;
      $rose(bus_drv_en) |-> $past(chip_mode) == CHIP_NORMAL;
   endproperty
   a_drv_chip: assert property (p_drv_chip) else $error("driver outside chip normal");
   property p_irq_cause;
      $fell(irq_out_n) |-> $past(chip_mode) inside {CHIP_NORMAL, CHIP_STOP} && !can_rx_output;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("interrupt from wrong mode");
   property p_restart_src;
      chip_restart_req |-> $past(chip_mode) inside {CHIP_SLEEP, CHIP_FAILSAFE} && irq_out_n
         ##1 !chip_restart_req;
   endproperty
   a_restart_src: assert property (p_restart_src) else $error("bad restart request");
   property p_wdog_src;
      wdog_enable_req |-> $past(chip_mode) == CHIP_STOP && !can_rx_output ##1 !wdog_enable_req;
   endproperty
   a_wdog_src: assert property (p_wdog_src) else $error("bad watchdog request");
   property p_wake_rx;
      $fell(irq_out_n) |=> !can_rx_output [*3];
   endproperty
   a_wake_rx: assert property (p_wake_rx) else $error("receive output not held low");
endmodule : ctw_transceiver_chk
bind ctw_transceiver ctw_transceiver_chk #(.TX_TO_C(TX_TO_C)) chk_u (
   .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .chip_mode(chip_mode), .can_tx_input(can_tx_input),
   .can_rx_output(can_rx_output), .irq_out_n(irq_out_n), .bus_drive_dom(bus_drive_dom),
   .bus_drv_en(bus_drv_en), .chip_restart_req(chip_restart_req),
   .wdog_enable_req(wdog_enable_req));
`default_nettype wire

// >>> tb/ctw_ctrl_model.sv
`default_nettype none
module ctw_ctrl_model
   import ctw_pkg::*;
(
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Commands from the bench.
   input  wire logic enable_seen,
   input  wire logic tx_want,
   input  wire logic polite,
   // Controller transmit pin.
   output logic      can_tx_input
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] wait_r;
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || enable_seen)
         wait_r <= 16'(TX_EN_CYC);
      else if (wait_r != 16'h0)
         wait_r <= wait_r - 16'h1;
   end
   // A careless controller (polite low) may pull the pin early; a careful one waits.
   assign can_tx_input = (wait_r == 16'h0 || !polite) ? tx_want : 1'b1;
endmodule : ctw_ctrl_model
`default_nettype wire

// >>> tb/ctw_transceiver_tb_top.sv
`default_nettype none
module ctw_transceiver_tb_top import ctw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WMAX = 40;
   logic           clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, bus_rx_dec;
   logic [2:0]     avs_address;
   logic [31:0]    avs_writedata, avs_readdata, got;
   logic [3:0]     avs_byteenable;
   ctw_chip_mode_t chip_mode;
   logic           can_tx_input, can_rx_output, irq_out_n, bus_drive_dom, bus_drv_en;
   logic           bus_gnd_term, chip_restart_req, wdog_enable_req;
   logic           enable_seen, tx_want, polite, pin_req;
   logic           pulse_req, rst_seen, wdog_seen;
   logic [63:0]    exp_q[$];
   logic [63:0]    note;
   int             errors, n_checks, cyc, seed;
   ctw_transceiver #(.WAKE_MAX_C(WMAX), .TX_TO_C(50), .SILENCE_C(20)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chip_mode(chip_mode),
      .can_tx_input(can_tx_input), .can_rx_output(can_rx_output), .irq_out_n(irq_out_n),
      .bus_rx_dec(bus_rx_dec), .bus_drive_dom(bus_drive_dom), .bus_drv_en(bus_drv_en),
      .bus_gnd_term(bus_gnd_term), .chip_restart_req(chip_restart_req),
      .wdog_enable_req(wdog_enable_req));
   ctw_ctrl_model model_u (.clk_sys(clk_sys), .rst_n(rst_n), .enable_seen(enable_seen),
      .tx_want(tx_want), .polite(polite), .can_tx_input(can_tx_input));
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic close_out();
   begin
      $display("Counts: errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask : close_out
   // Reads, pin samples and pulse checks all land here, oldest note first.
   // Request pulses last one cycle, so they are caught here and checked later.
   always @(posedge clk_sys)
   begin
      cyc++;
      if (!rst_n)
         {rst_seen, wdog_seen} = 2'b00;
      else
         {rst_seen, wdog_seen} = {rst_seen | chip_restart_req, wdog_seen | wdog_enable_req};
      if ((avs_read && !avs_waitrequest) || pin_req || pulse_req)
      begin
         note = exp_q.pop_front();
         got = pulse_req ? {30'h0, rst_seen, wdog_seen} :
               pin_req ? {27'h0, can_rx_output, irq_out_n, bus_drive_dom, bus_drv_en,
                          bus_gnd_term} : avs_readdata;
         n_checks++;
         if ((got & note[63:32]) !== note[31:0])
         begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got & note[63:32], note[31:0]);
         end
         if (pulse_req)
            {rst_seen, wdog_seen} = 2'b00;
      end
      if (cyc == 20000)
      begin
         errors++;
         close_out();
      end
   end
   task automatic xfer(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       input logic [31:0] m);
   begin
      @(posedge clk_sys);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      if (!wr)
         exp_q.push_back({m, d & m});
      do
         @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   end
   endtask : xfer
   task automatic pins(input logic [4:0] e, input logic [4:0] m);
   begin
      @(posedge clk_sys);
      exp_q.push_back({27'h0, m, 27'h0, e & m});
      pin_req <= 1'b1;
      @(posedge clk_sys);
      pin_req <= 1'b0;
   end
   endtask : pins
   task automatic pulses(input logic [1:0] e);
   begin
      @(posedge clk_sys);
      exp_q.push_back({32'h3, 30'h0, e});
      pulse_req <= 1'b1;
      @(posedge clk_sys);
      pulse_req <= 1'b0;
   end
   endtask : pulses
   // Length zero asks for random phases, kept inside the legal window.
   task automatic wake_pat(input int lo);
      int n;
   begin
      for (int k = 0; k < 3; k++)
      begin
         n = (lo == 0) ? 5 + ({$random(seed)} % (WMAX - 10)) : lo;
         repeat (n) @(posedge clk_sys) bus_rx_dec <= (k == 1);
      end
      @(posedge clk_sys) bus_rx_dec <= 1'b1;
      repeat (6) @(posedge clk_sys);
   end
   endtask : wake_pat
   initial
   begin
      seed = 32'h6925c4dd;
      rst_n = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      chip_mode = CHIP_NORMAL;
      {bus_rx_dec, tx_want, polite, enable_seen, pin_req, pulse_req} = 6'b111000;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      xfer(1'b0, ADDR_CTRL, 32'h0, 32'h7);
      xfer(1'b0, 3'h2, 32'h0, 32'hffffffff);
      pins(5'b11000, 5'b11111);
      for (int k = 0; k < 4; k++)
      begin
         xfer(1'b1, ADDR_CTRL, 32'(k), 32'h0);
         xfer(1'b0, ADDR_STATUS, 32'(k), 32'h3);
      end
      xfer(1'b1, ADDR_CTRL, 32'(MODE_OFF), 32'h0);
      wake_pat(0);
      xfer(1'b0, ADDR_STATUS, 32'h0, 32'h0c);
      chip_mode <= CHIP_STOP;
      xfer(1'b1, ADDR_CTRL, 32'(MODE_NORMAL), 32'h0);
      xfer(1'b0, ADDR_CTRL, 32'(MODE_OFF), 32'h3);
      xfer(1'b1, ADDR_CTRL, 32'(MODE_RXONLY), 32'h0);
      xfer(1'b0, ADDR_CTRL, 32'(MODE_RXONLY), 32'h3);
      xfer(1'b1, ADDR_CTRL, 32'h4 | 32'(MODE_WAKE), 32'h0);
      repeat (26) @(posedge clk_sys);
      pins(5'b11001, 5'b11111);
      wake_pat(3);
      wake_pat(WMAX + 5);
      pins(5'b11000, 5'b11000);
      wake_pat(0);
      pins(5'b00000, 5'b11000);
      pulses(2'b01);
      xfer(1'b0, ADDR_STATUS, 32'h0d, 32'h0f);
      xfer(1'b1, ADDR_STATUS, 32'h0c, 32'h0);
      pins(5'b01000, 5'b11000);
      wake_pat(0);
      xfer(1'b0, ADDR_STATUS, 32'h01, 32'h0f);
      xfer(1'b1, ADDR_CTRL, 32'(MODE_OFF), 32'h0);
      xfer(1'b1, ADDR_CTRL, 32'(MODE_WAKE), 32'h0);
      pins(5'b11000, 5'b11000);
      wake_pat(0);
      xfer(1'b0, ADDR_STATUS, 32'h04, 32'h04);
      pulses(2'b00);
      xfer(1'b1, ADDR_STATUS, 32'h0c, 32'h0);
      chip_mode <= CHIP_SLEEP;
      repeat (3) @(posedge clk_sys);
      pins(5'b11000, 5'b11000);
      wake_pat(0);
      pins(5'b01000, 5'b11000);
      pulses(2'b10);
      xfer(1'b0, ADDR_STATUS, 32'h04, 32'h0c);
      xfer(1'b1, ADDR_CTRL, 32'(MODE_OFF), 32'h0);
      xfer(1'b0, ADDR_CTRL, 32'(MODE_OFF), 32'h3);
      chip_mode <= CHIP_FAILSAFE;
      xfer(1'b1, ADDR_STATUS, 32'h0c, 32'h0);
      xfer(1'b0, ADDR_CTRL, 32'(MODE_WAKE), 32'h3);
      wake_pat(0);
      pins(5'b01000, 5'b11000);
      pulses(2'b10);
      chip_mode <= CHIP_RESTART;
      xfer(1'b1, ADDR_CTRL, 32'(MODE_OFF), 32'h0);
      xfer(1'b1, ADDR_CTRL, 32'(MODE_WAKE), 32'h0);
      wake_pat(0);
      pins(5'b01000, 5'b11000);
      pulses(2'b00);
      chip_mode <= CHIP_NORMAL;
      polite <= 1'b0;
      tx_want <= 1'b0;
      xfer(1'b1, ADDR_CTRL, 32'(MODE_NORMAL), 32'h0);
      repeat (TX_EN_CYC + 10) @(posedge clk_sys);
      pins(5'b10000, 5'b10100);
      tx_want <= 1'b1;
      repeat (5) @(posedge clk_sys) tx_want <= 1'b0;
      repeat (5) @(posedge clk_sys);
      pins(5'b00110, 5'b00110);
      bus_rx_dec <= 1'b0;
      repeat (4) @(posedge clk_sys);
      pins(5'b00000, 5'b10000);
      bus_rx_dec <= 1'b1;
      repeat (60) @(posedge clk_sys);
      pins(5'b00000, 5'b00100);
      xfer(1'b0, ADDR_STATUS, 32'h33, 32'h33);
      tx_want <= 1'b1;
      repeat (5) @(posedge clk_sys) tx_want <= 1'b0;
      repeat (5) @(posedge clk_sys);
      pins(5'b00110, 5'b00110);
      xfer(1'b1, ADDR_CTRL, 32'(MODE_RXONLY), 32'h0);
      pins(5'b00000, 5'b00110);
      polite <= 1'b1;
      xfer(1'b1, ADDR_CTRL, 32'(MODE_NORMAL), 32'h0);
      enable_seen <= 1'b1;
      @(posedge clk_sys) enable_seen <= 1'b0;
      repeat (TX_EN_CYC + 10) @(posedge clk_sys);
      pins(5'b00110, 5'b00110);
      tx_want <= 1'b1;
      close_out();
   end
endmodule : ctw_transceiver_tb_top
`default_nettype wire
